/* File: verilog/adc_link_pkg.sv */
// Shared constants for the converter serial readout link
package adc_link_pkg;
	// ============================================================
	// Word and clock counts
	localparam int unsigned WORD_BITS      = 24;
	localparam int unsigned CLKS_READ      = 24;
	localparam int unsigned CLKS_RELEASE   = 25;
	localparam int unsigned CLKS_CAL       = 26;
	localparam logic [4:0]  EDGE_IDLE      = 5'h1f;
	// ============================================================
	// Device timing on the link clock
	localparam int unsigned LINK_PERIOD_NS = 125;
	localparam int unsigned CONV_CLKS_SLOW = 491520;
	localparam int unsigned CONV_CLKS_FAST = 61440;
	localparam int unsigned UPD_TIME_US    = 39;
	localparam int unsigned UPD_CYC        = (UPD_TIME_US * 1000 + LINK_PERIOD_NS - 1)
	                                         / LINK_PERIOD_NS;
	localparam int unsigned XTAL_START_MS  = 20;
	localparam int unsigned XTAL_START_CYC = XTAL_START_MS * 1000000 / LINK_PERIOD_NS;
	localparam int unsigned CAL_CONVS      = 8;
	localparam int unsigned WAKE_CONVS     = 4;
	// ============================================================
	// Host timing on the main clock
	localparam int unsigned MCLK_PERIOD_NS = 50;
	localparam int unsigned SCLK_MIN_NS    = 100;
	localparam int unsigned SCLK_MIN_CYC   = (SCLK_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int unsigned SCLK_HALF_CYC  = 16 * SCLK_MIN_CYC;
	// ============================================================
	// Host commands
	typedef enum logic [1:0] {
		OP_READ     = 2'h0,
		OP_RELEASE  = 2'h1,
		OP_CAL      = 2'h2,
		OP_CAL_STBY = 2'h3
	} host_op_e;
endpackage

/* File: verilog/adc_link_if.sv */
// Serial readout link between host controller and converter
`timescale 1ns/1ps
interface adc_link_if;
	logic sclk;             // Serial shift clock, host driven
	logic data_out_ready_n; // Data out, low means word ready
	logic power_down_n;     // Low powers the converter down

	modport device (
		input  sclk,
		input  power_down_n,
		output data_out_ready_n
	);
	modport host (
		output sclk,
		output power_down_n,
		input  data_out_ready_n
	);
endinterface

/* File: verilog/adc_dev_end.sv */
// Converter end: conversion sequencing, serial readout, calibration, standby
//
// Overview of operation
// - Converts continuously by itself after reset
// - Ready output falls when conversion finishes
// - MSB first, next bit each clock rise
// - Host captures bits on falling clock edge
// - LSB held; high pulse then low
// - New word overwrites bits not shifted out
// - Host keeps clock low while ready high
// - Twenty-fifth clock forces ready high until next
// - Twenty-six clocks start offset calibration immediately
// - Calibration stores offset, subtracted from later words
// - Ready falls when calibration finishes
// - Clock held high after ready enters standby
// - Standby powers down all but oscillator
// - Clock low leaves standby, ready after conversion
// - Extra clocks then standby calibrate on exit
// - Power-down rising edge only after supplies settle
// - Power-down low shuts everything including oscillator
// - External clock resumes at once, crystal delayed
// - Rate input selects slow or fast periods
// - Two's complement word, clipped when out of range
`timescale 1ns/1ps
module adc_dev_end #(
	parameter int unsigned CONV_CYC_SLOW = adc_link_pkg::CONV_CLKS_SLOW, // Cycles per slow conversion
	parameter int unsigned CONV_CYC_FAST = adc_link_pkg::CONV_CLKS_FAST, // Cycles per fast conversion
	parameter int unsigned XTAL_CYC      = adc_link_pkg::XTAL_START_CYC, // Crystal start-up cycles
	parameter int unsigned CAL_CONVS     = adc_link_pkg::CAL_CONVS,      // Periods per calibration
	parameter int unsigned WAKE_CONVS    = adc_link_pkg::WAKE_CONVS      // Periods after standby
) (
	input  wire logic               link_clk_in,         // Converter master clock
	input  wire logic               reset_in,            // Synchronous reset, active high
	input  wire logic               rate_fast_in,        // High selects fast rate
	input  wire logic               xtal_sel_in,         // High when running from crystal
	input  wire logic signed [24:0] sample_in,           // Raw modulator result
	output logic                    inputs_shorted_out,  // Front end inputs shorted
	output logic                    analog_on_out,       // Analog circuits powered
	output logic                    osc_on_out,          // Oscillator amplifier powered
	output logic                    word_done_out,       // Pulse as ready falls
	adc_link_if.device              link                 // Serial link
);
	// ============================================================
	// Types and constants
	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_CONV  = 2'b01,
		ST_CAL   = 2'b11,
		ST_STBY  = 2'b10
	} dev_state_e;

	localparam logic [18:0] PER_SLOW = 19'(CONV_CYC_SLOW - 1);
	localparam logic [18:0] PER_FAST = 19'(CONV_CYC_FAST - 1);
	localparam logic [18:0] XTAL_END = 19'(XTAL_CYC - 1);
	localparam logic [3:0]  CAL_SKIP = 4'(CAL_CONVS - 1);
	localparam logic [3:0]  WAKE_SKIP = 4'(WAKE_CONVS - 1);
	localparam logic [8:0]  UPD_LOAD = 9'(adc_link_pkg::UPD_CYC);
	localparam logic [4:0]  LAST_BIT = 5'(adc_link_pkg::CLKS_READ - 1);
	localparam logic [4:0]  RELEASE_EDGE = 5'(adc_link_pkg::CLKS_RELEASE - 1);
	localparam logic [4:0]  CAL_EDGE = 5'(adc_link_pkg::CLKS_CAL - 1);

	dev_state_e         state_q;
	logic [2:0]         sclk_sync_q;
	logic [2:0]         pd_sync_q;
	logic               sclk_lvl_q;
	logic               pd_lvl_q;
	logic               rst;
	logic               sclk_rise;
	logic [18:0]        timer_q;
	logic [18:0]        period;
	logic [3:0]         skip_q;
	logic               tick;
	logic               done;
	logic               cal_go;
	logic               cal_pend_q;
	logic signed [23:0] offset_q;
	logic [23:0]        word_d;
	logic [23:0]        word_q;
	logic [23:0]        shreg_q;
	logic [4:0]         edge_q;
	logic [8:0]         upd_q;
	logic               dout_q;

	// Saturate a wide signed value into the word range
	function automatic logic [23:0] clip24(input logic signed [25:0] v);
		if (v > 26'sh07f_ffff) begin
			clip24 = 24'h7f_ffff;
		end else if (v < -26'sh080_0000) begin
			clip24 = 24'h80_0000;
		end else begin
			clip24 = v[23:0];
		end
	endfunction

	// ============================================================
	// Pin synchronisers; a level counts once stages two and three agree
	always_ff @(posedge link_clk_in) begin
		if (reset_in) begin
			sclk_sync_q <= 3'h0;
			pd_sync_q   <= 3'h0;
			sclk_lvl_q  <= 1'b0;
			pd_lvl_q    <= 1'b0;
		end else begin
			sclk_sync_q <= {sclk_sync_q[1:0], link.sclk};
			pd_sync_q   <= {pd_sync_q[1:0], link.power_down_n};
			if (sclk_sync_q[1] == sclk_sync_q[2]) begin
				sclk_lvl_q <= sclk_sync_q[2];
			end
			if (pd_sync_q[1] == pd_sync_q[2]) begin
				pd_lvl_q <= pd_sync_q[2];
			end
		end
	end

	// Power-down low holds everything but the pin synchronisers in reset
	assign rst       = reset_in | ~pd_lvl_q;
	assign sclk_rise = sclk_sync_q[1] & sclk_sync_q[2] & ~sclk_lvl_q;

	// ============================================================
	// Conversion sequencing
	assign period = rate_fast_in ? PER_FAST : PER_SLOW;
	assign tick   = (timer_q == period);
	assign done   = tick && (skip_q == 4'h0) && !sclk_lvl_q &&
	                ((state_q == ST_CONV) || (state_q == ST_CAL));
	assign cal_go = sclk_rise && (edge_q == CAL_EDGE) && (upd_q == 9'h000) &&
	                (state_q == ST_CONV);

	always_ff @(posedge link_clk_in) begin
		if (rst) begin
			state_q <= ST_START;
			timer_q <= 19'h0_0000;
			skip_q  <= 4'h0;
		end else begin
			case (state_q)
				ST_START: begin
					if (!xtal_sel_in || timer_q == XTAL_END) begin
						state_q <= ST_CONV;
						timer_q <= 19'h0_0000;
					end else begin
						timer_q <= timer_q + 19'h0_0001;
					end
				end
				ST_CONV, ST_CAL: begin
					if (cal_go) begin
						state_q <= ST_CAL;
						timer_q <= 19'h0_0000;
						skip_q  <= CAL_SKIP;
					end else if (tick) begin
						timer_q <= 19'h0_0000;
						if (skip_q != 4'h0) begin
							skip_q <= skip_q - 4'h1;
						end else if (sclk_lvl_q) begin
							state_q <= ST_STBY;
						end else begin
							state_q <= ST_CONV;
						end
					end else begin
						timer_q <= timer_q + 19'h0_0001;
					end
				end
				ST_STBY: begin
					timer_q <= 19'h0_0000;
					if (!sclk_lvl_q) begin
						state_q <= cal_pend_q ? ST_CAL : ST_CONV;
						skip_q  <= cal_pend_q ? CAL_SKIP : WAKE_SKIP;
					end
				end
				default: begin
					state_q <= ST_START;
				end
			endcase
		end
	end

	// ============================================================
	// Offset calibration
	always_ff @(posedge link_clk_in) begin
		if (rst) begin
			cal_pend_q <= 1'b0;
			offset_q   <= 24'sh00_0000;
		end else begin
			if (cal_go) begin
				cal_pend_q <= 1'b1;
			end else if (done && state_q == ST_CAL) begin
				cal_pend_q <= 1'b0;
			end
			if (tick && skip_q == 4'h0 && state_q == ST_CAL) begin
				offset_q <= signed'(clip24(26'(sample_in)));
			end
		end
	end

	// Offset removed and result clipped; a calibration reports zero
	assign word_d = (state_q == ST_CAL) ? 24'h00_0000 :
	                clip24(26'(sample_in) - 26'(offset_q));

	// ============================================================
	// Serial readout
	always_ff @(posedge link_clk_in) begin
		if (rst) begin
			dout_q  <= 1'b1;
			upd_q   <= 9'h000;
			word_q  <= 24'h00_0000;
			shreg_q <= 24'h00_0000;
			edge_q  <= adc_link_pkg::EDGE_IDLE;
		end else if (done) begin
			dout_q <= 1'b1;
			upd_q  <= UPD_LOAD;
			word_q <= word_d;
		end else if (upd_q != 9'h000) begin
			upd_q <= upd_q - 9'h001;
			if (upd_q == 9'h001) begin
				dout_q  <= 1'b0;
				shreg_q <= word_q;
				edge_q  <= 5'h00;
			end
		end else if (sclk_rise && state_q != ST_STBY) begin
			if (edge_q != adc_link_pkg::EDGE_IDLE) begin
				edge_q <= edge_q + 5'h01;
			end
			if (edge_q <= LAST_BIT) begin
				dout_q  <= shreg_q[23];
				shreg_q <= {shreg_q[22:0], 1'b0};
			end else if (edge_q == RELEASE_EDGE) begin
				dout_q <= 1'b1;
			end
		end
	end

	assign link.data_out_ready_n = dout_q;
	assign inputs_shorted_out    = (state_q == ST_CAL);
	assign analog_on_out         = !rst && (state_q != ST_STBY);
	assign osc_on_out            = pd_lvl_q;
	assign word_done_out         = (upd_q == 9'h001) && !done;

endmodule // adc_dev_end

/* File: verilog/adc_host_end.sv */
// Host end: power control, serial clock generation and word capture
`timescale 1ns/1ps
module adc_host_end #(
	parameter int unsigned HALF_CYC = adc_link_pkg::SCLK_HALF_CYC // Main clocks per clock half
) (
	input  wire logic        mclk_in,        // Main clock
	input  wire logic        reset_in,       // Synchronous reset, active high
	input  wire logic        power_en_in,    // High releases power-down
	input  wire logic        cmd_valid_in,   // Command request
	input  wire logic [1:0]  cmd_op_in,      // Command code
	output logic             cmd_ready_out,  // Command can be taken
	input  wire logic        standby_in,     // Hold converter in standby
	output logic [23:0]      word_out,       // Last word read
	output logic             word_valid_out, // Pulse when word_out updates
	output logic             busy_out,       // Clocking or holding
	adc_link_if.host         link            // Serial link
);
	// ============================================================
	// Types and state
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_HIGH = 2'b01,
		H_LOW  = 2'b11,
		H_HOLD = 2'b10
	} host_state_e;

	localparam logic [7:0] HALF_END = 8'(HALF_CYC - 1);
	localparam logic [4:0] LAST_BIT = 5'(adc_link_pkg::CLKS_READ - 1);

	host_state_e state_q;
	logic [2:0]  rdy_sync_q;
	logic        rdy_lvl_q;
	logic        armed_q;
	logic        power_q;
	logic        sclk_q;
	logic        hold_after_q;
	logic [7:0]  half_q;
	logic [4:0]  edges_q;
	logic [4:0]  nclk_q;
	logic [23:0] shift_q;
	logic        start;
	logic        stby_go;

	function automatic logic [4:0] op_clks(input logic [1:0] op);
		case (op)
			adc_link_pkg::OP_READ:    op_clks = 5'(adc_link_pkg::CLKS_READ);
			adc_link_pkg::OP_RELEASE: op_clks = 5'(adc_link_pkg::CLKS_RELEASE);
			default:                  op_clks = 5'(adc_link_pkg::CLKS_CAL);
		endcase
	endfunction

	// ============================================================
	// Ready synchroniser and new-word tracking
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			rdy_sync_q <= 3'h7;
			rdy_lvl_q  <= 1'b1;
			power_q    <= 1'b0;
		end else begin
			rdy_sync_q <= {rdy_sync_q[1:0], link.data_out_ready_n};
			power_q    <= power_en_in;
			if (rdy_sync_q[1] == rdy_sync_q[2]) begin
				rdy_lvl_q <= rdy_sync_q[2];
			end
		end
	end

	// Clock only after a fresh fall of ready
	assign cmd_ready_out = (state_q == H_IDLE) && armed_q && !rdy_lvl_q && power_q;
	assign start         = cmd_valid_in && cmd_ready_out;
	assign stby_go       = standby_in && !cmd_valid_in && cmd_ready_out;

	always_ff @(posedge mclk_in) begin
		if (reset_in || !power_q) begin
			armed_q <= 1'b0;
		end else if (start || stby_go) begin
			armed_q <= 1'b0;
		end else if (rdy_lvl_q) begin
			armed_q <= 1'b1;
		end
	end

	// ============================================================
	// Serial clock generation and capture
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state_q        <= H_IDLE;
			sclk_q         <= 1'b0;
			hold_after_q   <= 1'b0;
			half_q         <= 8'h00;
			edges_q        <= 5'h00;
			nclk_q         <= 5'h00;
			shift_q        <= 24'h00_0000;
			word_out       <= 24'h00_0000;
			word_valid_out <= 1'b0;
		end else begin
			word_valid_out <= 1'b0;
			case (state_q)
				H_IDLE: begin
					half_q  <= 8'h00;
					edges_q <= 5'h00;
					if (start) begin
						state_q      <= H_HIGH;
						sclk_q       <= 1'b1;
						nclk_q       <= op_clks(cmd_op_in);
						hold_after_q <= (cmd_op_in == adc_link_pkg::OP_CAL_STBY);
					end else if (stby_go) begin
						state_q <= H_HOLD;
						sclk_q  <= 1'b1;
					end
				end
				H_HIGH: begin
					if (half_q == HALF_END) begin
						half_q  <= 8'h00;
						sclk_q  <= 1'b0;
						state_q <= H_LOW;
						edges_q <= edges_q + 5'h01;
						if (edges_q <= LAST_BIT) begin
							shift_q <= {shift_q[22:0], rdy_lvl_q};
						end
						if (edges_q == LAST_BIT) begin
							word_out       <= {shift_q[22:0], rdy_lvl_q};
							word_valid_out <= 1'b1;
						end
					end else begin
						half_q <= half_q + 8'h01;
					end
				end
				H_LOW: begin
					if (half_q == HALF_END) begin
						half_q <= 8'h00;
						if (edges_q != nclk_q) begin
							state_q <= H_HIGH;
							sclk_q  <= 1'b1;
						end else if (hold_after_q && standby_in) begin
							state_q <= H_HOLD;
							sclk_q  <= 1'b1;
						end else begin
							state_q <= H_IDLE;
						end
					end else begin
						half_q <= half_q + 8'h01;
					end
				end
				H_HOLD: begin
					if (!standby_in) begin
						state_q <= H_IDLE;
						sclk_q  <= 1'b0;
					end
				end
				default: begin
					state_q <= H_IDLE;
					sclk_q  <= 1'b0;
				end
			endcase
		end
	end

	assign busy_out          = (state_q != H_IDLE);
	assign link.sclk         = sclk_q;
	assign link.power_down_n = power_q;

endmodule // adc_host_end

/* File: dv/adc_link_properties.sv */
// Concurrent checks on the converter serial link
`timescale 1ns/1ps
module adc_link_properties (
	input wire logic mclk_in,            // Host clock
	input wire logic link_clk_in,        // Converter clock
	input wire logic reset_in,           // Shared reset
	input wire logic sclk,               // Serial clock
	input wire logic data_out_ready_n,   // Data out, low ready
	input wire logic power_down_n,       // Power-down control
	input wire logic word_done_out,      // Ready fall pulse
	input wire logic analog_on_out,      // Analog powered
	input wire logic osc_on_out,         // Oscillator powered
	input wire logic inputs_shorted_out  // Inputs shorted
);
	// ============================================================
	// Helper counters
	logic [8:0] hi_run_q;
	logic [3:0] age_q;
	logic       last_q;
	logic [1:0] run_q;
	logic       prev_q;

	always_ff @(posedge link_clk_in) begin
		if (reset_in || !data_out_ready_n)
			hi_run_q <= 9'h000;
		else if (hi_run_q != 9'h1ff)
			hi_run_q <= hi_run_q + 9'h001;
	end

	always_ff @(posedge link_clk_in) begin
		last_q <= sclk;
		if (reset_in)
			age_q <= 4'hf;
		else if (sclk != last_q)
			age_q <= 4'h0;
		else if (age_q != 4'hf)
			age_q <= age_q + 4'h1;
	end

	always_ff @(posedge mclk_in) begin
		prev_q <= sclk;
		if (reset_in)
			run_q <= 2'h3;
		else if (sclk != prev_q)
			run_q <= 2'h0;
		else if (run_q != 2'h3)
			run_q <= run_q + 2'h1;
	end

	// ============================================================
	// Assertions
	AST_READY_FALL: assert property (@(posedge link_clk_in) disable iff (reset_in)
		word_done_out |-> data_out_ready_n ##1 !data_out_ready_n)
		else $error("ready pulse without falling ready");
	AST_UPDATE_GAP: assert property (@(posedge link_clk_in) disable iff (reset_in)
		word_done_out |-> hi_run_q >= 9'(adc_link_pkg::UPD_CYC - 1))
		else $error("ready high interval too short before new word");
	AST_FIRST_BIT_WAIT: assert property (@(posedge link_clk_in) disable iff (reset_in)
		word_done_out |=> !data_out_ready_n [*3])
		else $error("ready left low state without a clock rise");
	AST_FALL_CAUSE: assert property (@(posedge link_clk_in) disable iff (reset_in)
		$fell(data_out_ready_n) |-> $past(word_done_out) || age_q <= 4'h8)
		else $error("data line fell without clock edge or new word");
	AST_CAL_HIGH: assert property (@(posedge link_clk_in) disable iff (reset_in)
		inputs_shorted_out |-> data_out_ready_n)
		else $error("ready low during calibration");
	AST_CAL_POWERED: assert property (@(posedge link_clk_in) disable iff (reset_in)
		inputs_shorted_out |-> analog_on_out)
		else $error("calibration with analog section off");
	AST_PDN_OFF: assert property (@(posedge link_clk_in) disable iff (reset_in)
		!power_down_n [*8] |-> !osc_on_out && !analog_on_out && data_out_ready_n)
		else $error("circuits still on in power-down");
	AST_PDN_ON: assert property (@(posedge link_clk_in) disable iff (reset_in)
		power_down_n [*8] |-> osc_on_out)
		else $error("oscillator off while powered");
	AST_SCLK_WIDTH: assert property (@(posedge mclk_in) disable iff (reset_in)
		(sclk != prev_q) |-> run_q >= 2'(adc_link_pkg::SCLK_MIN_CYC - 1))
		else $error("serial clock phase too short");
endmodule // adc_link_properties

/* File: dv/tb_adc_serial_readout_control.sv */
// Self-checking bench for host and converter ends joined by the link
`timescale 1ns/1ps
module tb_adc_serial_readout_control;
	localparam int CONV_FAST = 800;
	localparam int CONV_SLOW = 1600;
	localparam int XTAL      = 50;
	logic               mclk_in = 1'h0;
	logic               link_clk_in = 1'h0;
	logic               reset_in = 1'h1;
	logic               power_en_in = 1'h0;
	logic               cmd_valid_in = 1'h0;
	logic               standby_in = 1'h0;
	logic               rate_fast_in = 1'h1;
	logic               xtal_sel_in = 1'h0;
	logic [1:0]         cmd_op_in = 2'h0;
	logic signed [24:0] sample_in = 25'h000_0000;
	logic signed [24:0] off = 25'h000_0000;
	logic signed [24:0] tab [6] = '{25'h080_0005, 25'h17f_fffb, 25'h000_0000,
		25'h1ff_ffff, 25'h07f_ffff, 25'h180_0000};
	logic               cmd_ready_out, word_valid_out, busy_out, word_done_out;
	logic               inputs_shorted_out, analog_on_out, osc_on_out;
	logic [23:0]        word_out;
	logic [23:0]        exp_q [$];
	int                 bad_count = 0, num_checks = 0, seed = 62, n_start, n0, n1;

	initial forever #25 mclk_in = ~mclk_in;
	initial begin
		#7;
		forever #62.5 link_clk_in = ~link_clk_in;
	end

	adc_link_if i_adc_link_if ();
	adc_dev_end #(.CONV_CYC_SLOW(CONV_SLOW), .CONV_CYC_FAST(CONV_FAST), .XTAL_CYC(XTAL),
		.CAL_CONVS(1), .WAKE_CONVS(1)) i_adc_dev_end (.link_clk_in(link_clk_in),
		.reset_in(reset_in), .rate_fast_in(rate_fast_in), .xtal_sel_in(xtal_sel_in),
		.sample_in(sample_in), .inputs_shorted_out(inputs_shorted_out),
		.analog_on_out(analog_on_out), .osc_on_out(osc_on_out),
		.word_done_out(word_done_out), .link(i_adc_link_if));
	adc_host_end #(.HALF_CYC(16)) i_adc_host_end (.mclk_in(mclk_in), .reset_in(reset_in),
		.power_en_in(power_en_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
		.cmd_ready_out(cmd_ready_out), .standby_in(standby_in), .word_out(word_out),
		.word_valid_out(word_valid_out), .busy_out(busy_out), .link(i_adc_link_if));
	adc_link_properties i_adc_link_properties (.mclk_in(mclk_in),
		.link_clk_in(link_clk_in), .reset_in(reset_in), .sclk(i_adc_link_if.sclk),
		.data_out_ready_n(i_adc_link_if.data_out_ready_n),
		.power_down_n(i_adc_link_if.power_down_n), .word_done_out(word_done_out),
		.analog_on_out(analog_on_out), .osc_on_out(osc_on_out),
		.inputs_shorted_out(inputs_shorted_out));

	// ============================================================
	// Compare and wait tasks
	task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t flag got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [23:0] clip(input logic signed [24:0] s);
		logic signed [25:0] d;
		d = s - off;
		if (d > 26'sh07f_ffff)
			return 24'h7f_ffff;
		if (d < -26'sh080_0000)
			return 24'h80_0000;
		return d[23:0];
	endfunction

	// Link cycles until the next new-word pulse
	task automatic meas(output int n);
		n = 0;
		do begin
			@(posedge link_clk_in);
			n++;
		end while (word_done_out !== 1'h1 && n < 40000);
	endtask

	task automatic wait_until(input int w);
		for (int k = 0; k < 40000; k++) begin
			@(posedge mclk_in);
			if (w == 0 && cmd_ready_out === 1'h1)
				return;
			if (w == 1 && analog_on_out === 1'h0)
				return;
			if (w == 2 && inputs_shorted_out === 1'h1)
				return;
			if (w == 3 && busy_out === 1'h0)
				return;
		end
	endtask

	task automatic do_op(input logic [1:0] op, input logic [23:0] e);
		wait_until(0);
		exp_q.push_back(e);
		cmd_valid_in <= 1'h1;
		cmd_op_in    <= op;
		@(posedge mclk_in);
		cmd_valid_in <= 1'h0;
	endtask

	task automatic rd(input logic signed [24:0] s, input logic [1:0] op);
		logic [23:0] e;
		int          n;
		e = clip(s);
		@(posedge mclk_in);
		sample_in <= s;
		meas(n);
		do_op(op, e);
		wait_until(3);
		if (op == 2'h0)
			cmp_bit(i_adc_link_if.data_out_ready_n, e[0]);
		if (op == 2'h1)
			cmp_bit(i_adc_link_if.data_out_ready_n, 1'h1);
		if (op == 2'h2)
			cmp_bit(inputs_shorted_out, 1'h1);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ============================================================
	// Word monitor and watchdog
	initial forever begin
		@(posedge mclk_in);
		if (word_valid_out === 1'h1)
			cmp_word(word_out, exp_q.size() > 0 ? exp_q.pop_front() : 24'hxx_xxxx);
	end

	initial begin
		repeat (95000) @(posedge mclk_in);
		bad_count++;
		conclude();
	end

	// ============================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge mclk_in);
		reset_in    <= 1'h0;
		power_en_in <= 1'h1;
		meas(n_start);
		@(negedge link_clk_in);
		cmp_bit(i_adc_link_if.data_out_ready_n, 1'h0);
		for (int i = 0; i < 8; i++)
			rd(i < 6 ? tab[i] : 25'($signed(24'($random(seed)))), 2'(i % 2));
		meas(n0);
		meas(n0);
		@(posedge mclk_in);
		rate_fast_in <= 1'h0;
		repeat (3) meas(n1);
		cmp_word(24'(n1 - n0), 24'(CONV_SLOW - CONV_FAST));
		@(posedge mclk_in);
		rate_fast_in <= 1'h1;
		rd(25'($signed(24'($random(seed)))), 2'h2);
		meas(n0);
		off = sample_in;
		do_op(2'h0, 24'h00_0000);
		wait_until(3);
		rd(25'($signed(24'($random(seed)))), 2'h0);
		wait_until(0);
		standby_in <= 1'h1;
		wait_until(1);
		cmp_bit(osc_on_out, 1'h1);
		repeat (200) @(posedge mclk_in);
		cmp_bit(analog_on_out, 1'h0);
		standby_in <= 1'h0;
		meas(n0);
		cmp_bit(word_done_out, 1'h1);
		do_op(2'h3, clip(sample_in));
		standby_in <= 1'h1;
		wait_until(1);
		repeat (100) @(posedge mclk_in);
		standby_in <= 1'h0;
		wait_until(2);
		cmp_bit(inputs_shorted_out, 1'h1);
		meas(n0);
		@(posedge mclk_in);
		power_en_in <= 1'h0;
		xtal_sel_in <= 1'h1;
		repeat (20) @(posedge mclk_in);
		cmp_bit(osc_on_out, 1'h0);
		cmp_bit(i_adc_link_if.data_out_ready_n, 1'h1);
		power_en_in <= 1'h1;
		meas(n1);
		cmp_bit(n1 >= n_start + XTAL - 2 && n1 <= n_start + XTAL, 1'h1);
		conclude();
	end
endmodule // tb_adc_serial_readout_control
